// ==== i2c_host_model.sv ====
module i2c_host_model (
	// Timing reference
	input wire logic sys_clk,
	// Bus lines
	input wire logic sda_wire,
	output logic scl_pin,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_pin = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick
	// Data moves mid low phase so it never flips under a high clock
	task automatic slot(input logic b, output logic r);
		tick(2);
		sda_low = !b;
		tick(2);
		scl_pin = 1'b1;
		tick(2);
		r = sda_wire;
		tick(2);
		scl_pin = 1'b0;
	endtask : slot
	task automatic start;
		sda_low = 1'b1;
		tick(6);
		scl_pin = 1'b0;
	endtask : start
	task automatic stop;
		tick(3);
		sda_low = 1'b1;
		tick(3);
		scl_pin = 1'b1;
		tick(6);
		sda_low = 1'b0;
		tick(6);
	endtask : stop
	task automatic send(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) slot(b[i], r);
		slot(1'b1, r);
		ack = !r;
	endtask : send
	task automatic recv(output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			slot(1'b1, r);
			b[i] = r;
		end
		slot(1'b1, r);
	endtask : recv
	task automatic wr(input logic [7:0] ab, input logic [7:0] ptr, input logic [7:0] d, output logic [2:0] acks);
		start;
		send(ab, acks[2]);
		send(ptr, acks[1]);
		send(d, acks[0]);
		stop;
	endtask : wr
	task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
		logic a;
		start;
		send(8'h26, a);
		send(ptr, a);
		stop;
		start;
		send(8'h27, a);
		recv(d);
		stop;
	endtask : rd
endmodule : i2c_host_model

// ==== i2c_line_watch.sv ====
module i2c_line_watch (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Raw bus lines
	input wire logic scl_pin,
	input wire logic sda_pin,
	// Synchronised levels and events
	output logic scl_s,
	output logic sda_s,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_seen,
	output logic stop_seen
);
	import sensor_i2c_pkg::*;

	logic scl_meta, sda_meta, scl_d, sda_d;
	logic next_scl_meta, next_sda_meta, next_scl_s, next_sda_s, next_scl_d, next_sda_d;

	always_comb begin
		next_scl_meta = scl_pin;
		next_sda_meta = sda_pin;
		next_scl_s = scl_meta;
		next_sda_s = sda_meta;
		next_scl_d = scl_s;
		next_sda_d = sda_s;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			scl_meta <= LINE_IDLE;
			sda_meta <= LINE_IDLE;
			scl_s <= LINE_IDLE;
			sda_s <= LINE_IDLE;
			scl_d <= LINE_IDLE;
			sda_d <= LINE_IDLE;
		end else begin
			scl_meta <= next_scl_meta;
			sda_meta <= next_sda_meta;
			scl_s <= next_scl_s;
			sda_s <= next_sda_s;
			scl_d <= next_scl_d;
			sda_d <= next_sda_d;
		end
	end

	// Only second-stage and later flops feed the detectors
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;

endmodule : i2c_line_watch

// ==== sensor_i2c_pkg.sv ====
package sensor_i2c_pkg;

	// Bus addressing
	localparam logic [6:0] TARGET_ADDR = 7'h13;
	localparam logic [7:0] REG_BASE = 8'h80;
	localparam logic [7:0] REG_LAST = 8'h90;
	localparam int REG_COUNT = 17;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Register indices (offset from REG_BASE)
	localparam logic [4:0] IDX_CMD = 5'h00;
	localparam logic [4:0] IDX_ID = 5'h01;
	localparam logic [4:0] IDX_LIGHT_HI = 5'h05;
	localparam logic [4:0] IDX_LIGHT_LO = 5'h06;
	localparam logic [4:0] IDX_NEAR_HI = 5'h07;
	localparam logic [4:0] IDX_NEAR_LO = 5'h08;

	// measurement_command bit positions
	localparam int CMD_LOCK = 7;
	localparam int CMD_LIGHT_RDY = 6;
	localparam int CMD_NEAR_RDY = 5;
	localparam int CMD_LIGHT_SS = 4;
	localparam int CMD_NEAR_SS = 3;
	localparam int CMD_LIGHT_EN = 2;
	localparam int CMD_NEAR_EN = 1;
	localparam int CMD_SELF_TIMED = 0;

	// Reset and fixed values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] PTR_RESET = REG_BASE;
	localparam logic LOCK_VALUE = 1'b1;
	localparam logic LINE_IDLE = 1'b1;

	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_addr = 3'b001,
		st_ptr = 3'b010,
		st_wdata = 3'b011,
		st_ack = 3'b100,
		st_rdata = 3'b101,
		st_mack = 3'b110
	} i2c_state_e;

endpackage : sensor_i2c_pkg

// ==== sensor_i2c_port_monitor.sv ====
module sensor_i2c_port_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Watched ports
	input wire logic scl_pin,
	input wire logic sda_oe,
	input wire logic int_request,
	input wire logic int_oe,
	input wire logic int_out,
	input wire logic light_start,
	input wire logic nearness_start,
	input wire logic self_timed_run,
	input wire logic light_periodic_run,
	input wire logic nearness_periodic_run
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_light_shot; light_start |-> !self_timed_run; endproperty
	a_light_shot: assert property (p_light_shot) else $error("light shot while self timed");
	property p_near_shot; nearness_start |-> !self_timed_run; endproperty
	a_near_shot: assert property (p_near_shot) else $error("nearness shot while self timed");
	property p_light_per; light_periodic_run |-> self_timed_run; endproperty
	a_light_per: assert property (p_light_per) else $error("light periodic without self timed");
	property p_near_per; nearness_periodic_run |-> self_timed_run; endproperty
	a_near_per: assert property (p_near_per) else $error("nearness periodic without self timed");
	property p_int_pull; int_request |=> int_oe && !int_out; endproperty
	a_int_pull: assert property (p_int_pull) else $error("interrupt not pulled low");
	property p_int_free; !int_request |=> !int_oe; endproperty
	a_int_free: assert property (p_int_free) else $error("interrupt not released");
	// Data may only move while the bus clock is low, else it reads as start or stop
	property p_sda_move; !$stable(sda_oe) |-> !scl_pin; endproperty
	a_sda_move: assert property (p_sda_move) else $error("data changed with clock high");
	property p_shot_once; light_start |=> !light_start; endproperty
	a_shot_once: assert property (p_shot_once) else $error("light shot repeated");
	cover property (light_start);
	cover property (nearness_start);
	cover property (light_periodic_run && nearness_periodic_run);
endmodule : sensor_i2c_port_monitor

bind sensor_i2c_register_port sensor_i2c_port_monitor mon (.sys_clk, .rst_b, .scl_pin, .sda_oe,
	.int_request, .int_oe, .int_out, .light_start, .nearness_start, .self_timed_run,
	.light_periodic_run, .nearness_periodic_run);

// ==== sensor_i2c_register_port.sv ====
module sensor_i2c_register_port #(
	parameter logic [7:0] ID_VALUE = 8'h5a // Arbitrary identity value
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// I2C bus, open drain data
	input wire logic scl_pin,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Interrupt pin, open drain
	input wire logic int_request,
	output logic int_out,
	output logic int_oe,
	// Measurement engine
	output logic light_start,
	output logic nearness_start,
	output logic self_timed_run,
	output logic light_periodic_run,
	output logic nearness_periodic_run,
	input wire logic light_done,
	input wire logic [15:0] light_result,
	input wire logic nearness_done,
	input wire logic [15:0] nearness_result,
	// Register image for the setup consumers
	output logic [8*sensor_i2c_pkg::REG_COUNT-1:0] register_image
);
	import sensor_i2c_pkg::*;

	function automatic logic ptr_ok(input logic [7:0] p);
		return (p >= REG_BASE) && (p <= REG_LAST);
	endfunction : ptr_ok

	function automatic logic [4:0] ptr_idx(input logic [7:0] p);
		logic [7:0] d;
		d = p - REG_BASE;
		return d[4:0];
	endfunction : ptr_idx

	logic scl_s, sda_s, scl_rise, scl_fall, start_seen, stop_seen;

	i2c_line_watch u_watch (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.scl_pin(scl_pin),
		.sda_pin(sda_in),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_seen(start_seen),
		.stop_seen(stop_seen)
	);

	i2c_state_e state, next_state, after_ack, next_after_ack;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shreg, next_shreg;
	logic [7:0] ptr, next_ptr;
	logic next_sda_oe;
	logic light_ready, next_light_ready, near_ready, next_near_ready;
	logic light_ss, next_light_ss, near_ss, next_near_ss;
	logic light_en, next_light_en, near_en, next_near_en;
	logic self_timed, next_self_timed;
	logic next_light_start, next_nearness_start;
	logic next_light_run, next_near_run, next_int_oe;
	logic [7:0] regs [0:REG_COUNT-1];
	logic [7:0] next_regs [0:REG_COUNT-1];
	logic [7:0] cmd_byte, rd_byte;
	logic [4:0] cur_idx;
	logic load_byte, wr_en;

	assign cur_idx = ptr_idx(ptr);
	assign cmd_byte = {LOCK_VALUE, light_ready, near_ready, light_ss, near_ss, light_en, near_en, self_timed};

	always_comb begin
		rd_byte = REG_RESET;
		if (ptr_ok(ptr)) begin
			case (cur_idx)
				IDX_CMD: rd_byte = cmd_byte;
				IDX_ID: rd_byte = ID_VALUE;
				default: rd_byte = regs[cur_idx];
			endcase
		end
	end

	// Bus protocol
	always_comb begin
		next_state = state;
		next_after_ack = after_ack;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_ptr = ptr;
		next_sda_oe = sda_oe;
		load_byte = 1'b0;
		wr_en = 1'b0;
		if (stop_seen) begin
			next_state = st_idle;
			next_sda_oe = 1'b0;
		end else if (start_seen) begin
			next_state = st_addr;
			next_bit_cnt = '0;
			next_sda_oe = 1'b0;
		end else if (scl_rise) begin
			case (state)
				st_addr, st_ptr, st_wdata: begin
					next_shreg = {shreg[6:0], sda_s};
					next_bit_cnt = bit_cnt + 4'h1;
				end
				st_rdata: next_bit_cnt = bit_cnt + 4'h1;
				st_mack: begin
					// Host not acknowledging ends the read burst
					if (sda_s) begin
						next_state = st_idle;
					end
				end
				default: ;
			endcase
		end else if (scl_fall) begin
			case (state)
				st_addr: begin
					if (bit_cnt == BITS_PER_BYTE) begin
						if (shreg[7:1] == TARGET_ADDR) begin
							next_sda_oe = 1'b1;
							next_state = st_ack;
							next_after_ack = shreg[0] ? st_rdata : st_ptr;
						end else begin
							next_state = st_idle;
						end
					end
				end
				st_ptr: begin
					if (bit_cnt == BITS_PER_BYTE) begin
						next_ptr = shreg;
						next_sda_oe = 1'b1;
						next_state = st_ack;
						next_after_ack = st_wdata;
					end
				end
				st_wdata: begin
					if (bit_cnt == BITS_PER_BYTE) begin
						wr_en = 1'b1;
						next_sda_oe = 1'b1;
						next_state = st_ack;
						next_after_ack = st_wdata;
					end
				end
				st_ack: begin
					next_sda_oe = 1'b0;
					next_bit_cnt = '0;
					next_state = after_ack;
					load_byte = (after_ack == st_rdata);
				end
				st_rdata: begin
					if (bit_cnt == BITS_PER_BYTE) begin
						next_sda_oe = 1'b0;
						next_state = st_mack;
					end else begin
						next_shreg = {shreg[6:0], 1'b0};
						next_sda_oe = ~shreg[6];
					end
				end
				st_mack: begin
					next_bit_cnt = '0;
					next_state = st_rdata;
					load_byte = 1'b1;
				end
				default: ;
			endcase
		end
		if (load_byte) begin
			next_shreg = rd_byte;
			next_sda_oe = ~rd_byte[7];
		end
	end

	// Register file and command bits
	always_comb begin
		for (int i = 0; i < REG_COUNT; i++) begin
			next_regs[i] = regs[i];
		end
		next_light_ready = light_ready;
		next_near_ready = near_ready;
		next_light_ss = light_ss;
		next_near_ss = near_ss;
		next_light_en = light_en;
		next_near_en = near_en;
		next_self_timed = self_timed;
		next_light_start = 1'b0;
		next_nearness_start = 1'b0;
		// Reads of result registers clear the matching ready flag
		if (load_byte && ptr_ok(ptr)) begin
			if (cur_idx == IDX_LIGHT_HI || cur_idx == IDX_LIGHT_LO) begin
				next_light_ready = 1'b0;
			end
			if (cur_idx == IDX_NEAR_HI || cur_idx == IDX_NEAR_LO) begin
				next_near_ready = 1'b0;
			end
		end
		if (wr_en && ptr_ok(ptr)) begin
			case (cur_idx)
				IDX_CMD: begin
					// Lock and ready bits are not writable
					next_light_en = shreg[CMD_LIGHT_EN];
					next_near_en = shreg[CMD_NEAR_EN];
					next_self_timed = shreg[CMD_SELF_TIMED];
					// Single shots refused while self-timed mode is on
					if (!self_timed && !shreg[CMD_SELF_TIMED]) begin
						if (shreg[CMD_LIGHT_SS] && !light_ss) begin
							next_light_ss = 1'b1;
							next_light_start = 1'b1;
						end
						if (shreg[CMD_NEAR_SS] && !near_ss) begin
							next_near_ss = 1'b1;
							next_nearness_start = 1'b1;
						end
					end
				end
				IDX_ID, IDX_LIGHT_HI, IDX_LIGHT_LO, IDX_NEAR_HI, IDX_NEAR_LO: ;
				default: next_regs[cur_idx] = shreg;
			endcase
		end
		// Completion after a clear in the same cycle still sets the flag
		if (light_done) begin
			next_regs[IDX_LIGHT_HI] = light_result[15:8];
			next_regs[IDX_LIGHT_LO] = light_result[7:0];
			next_light_ready = 1'b1;
			next_light_ss = 1'b0;
		end
		if (nearness_done) begin
			next_regs[IDX_NEAR_HI] = nearness_result[15:8];
			next_regs[IDX_NEAR_LO] = nearness_result[7:0];
			next_near_ready = 1'b1;
			next_near_ss = 1'b0;
		end
		// Rate registers are copied as written; safe use relies on the host
		next_light_run = next_self_timed & next_light_en;
		next_near_run = next_self_timed & next_near_en;
		next_int_oe = int_request;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state <= st_idle;
			after_ack <= st_idle;
			bit_cnt <= '0;
			shreg <= REG_RESET;
			ptr <= PTR_RESET;
			sda_oe <= 1'b0;
			light_ready <= 1'b0;
			near_ready <= 1'b0;
			light_ss <= 1'b0;
			near_ss <= 1'b0;
			light_en <= 1'b0;
			near_en <= 1'b0;
			self_timed <= 1'b0;
			light_start <= 1'b0;
			nearness_start <= 1'b0;
			light_periodic_run <= 1'b0;
			nearness_periodic_run <= 1'b0;
			int_oe <= 1'b0;
			for (int i = 0; i < REG_COUNT; i++) begin
				regs[i] <= REG_RESET;
			end
		end else begin
			state <= next_state;
			after_ack <= next_after_ack;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			ptr <= next_ptr;
			sda_oe <= next_sda_oe;
			light_ready <= next_light_ready;
			near_ready <= next_near_ready;
			light_ss <= next_light_ss;
			near_ss <= next_near_ss;
			light_en <= next_light_en;
			near_en <= next_near_en;
			self_timed <= next_self_timed;
			light_start <= next_light_start;
			nearness_start <= next_nearness_start;
			light_periodic_run <= next_light_run;
			nearness_periodic_run <= next_near_run;
			int_oe <= next_int_oe;
			for (int i = 0; i < REG_COUNT; i++) begin
				regs[i] <= next_regs[i];
			end
		end
	end

	// Open drain pins only ever pull low
	assign sda_out = 1'b0;
	assign int_out = 1'b0;
	assign self_timed_run = self_timed;

	always_comb begin
		for (int i = 0; i < REG_COUNT; i++) begin
			register_image[8*i +: 8] = regs[i];
		end
		register_image[8*IDX_CMD +: 8] = cmd_byte;
		register_image[8*IDX_ID +: 8] = ID_VALUE;
	end

endmodule : sensor_i2c_register_port

// ==== test_sensor_i2c_register_port.sv ====
module test_sensor_i2c_register_port;
	timeunit 1ns;
	timeprecision 1ps;
	import sensor_i2c_pkg::*;
	localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
	typedef struct {logic [7:0] ptr; logic [7:0] wd; logic [7:0] rb;} row_s;
	row_s rows [6] = '{'{8'h82, 8'ha5, 8'ha5}, '{8'h90, 8'h3c, 8'h3c}, '{8'h81, 8'hff, ID},
		'{8'h91, 8'h77, 8'h00}, '{8'h80, 8'he6, 8'h86}, '{8'h80, 8'h00, 8'h80}};
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic scl_pin, sda_low, sda_out, sda_oe, sda_wire, int_request, int_out, int_oe;
	logic light_start, nearness_start, self_timed_run, light_periodic_run, nearness_periodic_run;
	logic light_done, nearness_done;
	logic [15:0] light_result, nearness_result;
	logic [8*REG_COUNT-1:0] register_image;
	logic [7:0] d;
	logic [2:0] acks;
	int bad_count = 0;
	int checks_done = 0;
	int shots = 0;
	assign sda_wire = !((sda_oe && !sda_out) || sda_low);
	always #12.5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) if (light_start === 1'b1 || nearness_start === 1'b1) shots++;
	sensor_i2c_register_port #(.ID_VALUE(ID)) uut (.sys_clk, .rst_b, .scl_pin, .sda_in(sda_wire),
		.sda_out, .sda_oe, .int_request, .int_out, .int_oe, .light_start, .nearness_start,
		.self_timed_run, .light_periodic_run, .nearness_periodic_run, .light_done, .light_result,
		.nearness_done, .nearness_result, .register_image);
	i2c_host_model host (.sys_clk, .sda_wire, .scl_pin, .sda_low);
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic rdchk(input logic [7:0] ptr, input logic [7:0] exp);
		host.rd(ptr, d);
		chk("register", exp, d);
	endtask : rdchk
	task automatic done_pulse(input logic [1:0] which);
		@(negedge sys_clk) {light_done, nearness_done} = which;
		@(negedge sys_clk) {light_done, nearness_done} = 2'b00;
	endtask : done_pulse
	task automatic final_report;
		if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	initial begin
		{int_request, light_done, nearness_done} = 3'h0;
		light_result = 16'h1234;
		nearness_result = 16'h5678;
		repeat (6) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge sys_clk);
		chk("oe", 8'h00, {6'h00, sda_oe, int_oe});
		chk("id", ID, register_image[15:8]);
		rdchk(8'h80, 8'h80);
		foreach (rows[i]) begin
			host.wr(8'h26, rows[i].ptr, rows[i].wd, acks);
			chk("acks", 8'h07, {5'h00, acks});
			rdchk(rows[i].ptr, rows[i].rb);
		end
		host.wr(8'h28, 8'h82, 8'h11, acks);
		chk("foreign", 8'h00, {5'h00, acks});
		rdchk(8'h82, 8'ha5);
		host.wr(8'h26, 8'h80, 8'h10, acks);
		rdchk(8'h80, 8'h90);
		done_pulse(2'b10);
		rdchk(8'h80, 8'hc0);
		rdchk(8'h86, 8'h34);
		rdchk(8'h80, 8'h80);
		host.wr(8'h26, 8'h80, 8'h08, acks);
		done_pulse(2'b01);
		rdchk(8'h80, 8'ha0);
		rdchk(8'h87, 8'h56);
		rdchk(8'h80, 8'h80);
		host.wr(8'h26, 8'h80, 8'h07, acks);
		chk("run", 8'h07, {5'h00, self_timed_run, light_periodic_run, nearness_periodic_run});
		host.wr(8'h26, 8'h80, 8'h19, acks);
		rdchk(8'h80, 8'h81);
		chk("shots", 8'h02, 8'(shots));
		host.wr(8'h26, 8'h80, 8'h00, acks);
		int_request = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk("int", 8'h00, {7'h00, !(int_oe && !int_out)});
		int_request = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk("int", 8'h01, {7'h00, !(int_oe && !int_out)});
		// Reset in mid-run must wipe written registers and the pointer
		rst_b = 1'b0;
		repeat (6) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge sys_clk);
		chk("reset oe", 8'h00, {6'h00, sda_oe, int_oe});
		chk("reset image", 8'h00, register_image[23:16]);
		host.start;
		host.send(8'h27, acks[0]);
		host.recv(d);
		host.stop;
		chk("reset ack", 8'h01, {7'h00, acks[0]});
		chk("reset ptr", 8'h80, d);
		final_report;
	end
	initial begin
		repeat (50000) @(posedge sys_clk);
		bad_count++;
		final_report;
	end
endmodule : test_sensor_i2c_register_port
